// *** dv/bfr_properties.sv ***
// checker: properties of the fifo link between the host end and the device end
`timescale 1ns/10ps
`default_nettype none
module bfr_properties #(
  parameter int DATA_W = bfr_pkg::DATA_W,
  parameter int ADDR_W = bfr_pkg::ADDR_W
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              write_strobe,
  input wire logic              write_side_clock_enable,
  input wire logic              read_strobe,
  input wire logic              read_side_clock_enable,
  input wire logic [DATA_W-1:0] read_data,
  input wire logic              full_flag,
  input wire logic              almost_full_flag,
  input wire logic              almost_empty_flag,
  input wire logic              empty_flag,
  input wire logic              port_a_reset,
  input wire logic              port_b_reset,
  input wire logic              device_wide_reset_n,
  input wire logic [ADDR_W-1:0] full_thr,
  input wire logic [ADDR_W-1:0] almost_full_thr,
  input wire logic [ADDR_W-1:0] almost_empty_thr
);
  typedef struct packed {
    logic [ADDR_W:0] cnt;
    logic [ADDR_W:0] wcnt;
  } bfr_model_type;
  bfr_model_type st;
  bfr_model_type next_st;
  logic          any_rst;
  logic          quiet;
  logic          push_ok;
  logic          pop_ok;
  // ************************************************
  // word count model
  // ************************************************
  assign any_rst = port_a_reset | port_b_reset | ~device_wide_reset_n;
  assign quiet   = ~(write_strobe | write_side_clock_enable | read_strobe | read_side_clock_enable);
  assign push_ok = write_strobe & write_side_clock_enable & (st.cnt < {1'b0, full_thr});
  assign pop_ok  = read_strobe & read_side_clock_enable & (st.cnt != '0);
  always_comb begin
    next_st      = st;
    next_st.cnt  = st.cnt + {{ADDR_W{1'b0}}, push_ok} - {{ADDR_W{1'b0}}, pop_ok};
    next_st.wcnt = st.wcnt + {{ADDR_W{1'b0}}, push_ok};
    // rewind replays every word since the last fifo or device reset
    if (port_b_reset) begin
      next_st.cnt = st.wcnt;
    end
    if (port_a_reset || !device_wide_reset_n) begin
      next_st = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // ************************************************
  // properties
  // ************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // flags lag a threshold change or a reset by one cycle
  sequence s_settled;
    !any_rst && !$past(any_rst) && $stable(full_thr) && $stable(almost_full_thr)
      && $stable(almost_empty_thr);
  endsequence
  sequence s_idle_after;
    quiet [*3];
  endsequence
  a_full_level: assert property (
    s_settled |-> full_flag == (st.cnt >= {1'b0, full_thr}))
    else $error("full flag disagrees with word count");
  a_afull_level: assert property (
    s_settled |-> almost_full_flag == (st.cnt >= {1'b0, almost_full_thr}))
    else $error("almost full flag disagrees with word count");
  a_empty_level: assert property (
    s_settled |-> empty_flag == (st.cnt == '0))
    else $error("empty flag disagrees with word count");
  a_aempty_level: assert property (
    s_settled |-> almost_empty_flag == (st.cnt <= {1'b0, almost_empty_thr}))
    else $error("almost empty flag disagrees with word count");
  a_idle_around_reset: assert property (
    $rose(any_rst) |-> $past(quiet) ##0 s_idle_after)
    else $error("enables active around a reset pulse");
  a_fifo_reset_flags: assert property (
    port_a_reset |-> (empty_flag && !full_flag && !almost_full_flag) [*2])
    else $error("fifo reset left flags set");
  a_rptr_reset_latch: assert property (
    port_b_reset |-> read_data == '0)
    else $error("read pointer reset left read data");
  a_device_reset_clear: assert property (
    !device_wide_reset_n |-> read_data == '0 && empty_flag && !full_flag)
    else $error("device reset left state");
  a_read_data_holds: assert property (
    !(read_strobe && read_side_clock_enable) && !any_rst |=> $stable(read_data) || any_rst)
    else $error("read data changed without a pop");
  a_strobe_pairs: assert property (
    write_strobe || read_strobe |-> (write_strobe == write_side_clock_enable)
      && (read_strobe == read_side_clock_enable))
    else $error("strobe without its clock enable");
endmodule : bfr_properties
`default_nettype wire

// *** dv/bfr_tb.sv ***
// testbench: apb traffic through the host end into the device end
`timescale 1ns/10ps
`default_nettype none
module bfr_tb;
  localparam int         DW = bfr_pkg::DATA_W;
  localparam int         AW = bfr_pkg::ADDR_W;
  localparam logic [7:0] STAT = bfr_pkg::OFS_STATUS;
  localparam logic [7:0] RDAT = bfr_pkg::OFS_RDATA;
  localparam logic [7:0] WDAT = bfr_pkg::OFS_WDATA;
  localparam logic [7:0] CTRL = bfr_pkg::OFS_CTRL;
  localparam logic [7:0] ISTA = bfr_pkg::OFS_INT_STAT;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          irq;
  logic          port_a_enable = 1'b0;
  logic          port_a_write = 1'b0;
  logic [AW-1:0] port_a_addr = '0;
  logic [DW-1:0] port_a_wdata = '0;
  logic [DW-1:0] port_a_data;
  logic [33:0]   exp_q[$];
  logic [33:0]   note;
  logic [DW-1:0] w[4];
  logic [31:0]   seed = 32'hd000;
  logic [31:0]   r;
  int            fail_count = 0;
  int            checks = 0;
  int            cyc = 0;
  bfr_pkg::bfr_write_mode_type write_mode = bfr_pkg::WM_NORMAL;

  bfr_if bfr_if_i ();
  bfr_host bfr_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .lnk(bfr_if_i));
  bfr_device bfr_device_i (.pclk, .presetn, .lnk(bfr_if_i), .port_a_enable, .port_a_write,
    .port_a_addr, .port_a_wdata, .write_mode, .port_a_data);
  bfr_properties bfr_properties_i (.pclk, .presetn,
    .write_strobe(bfr_if_i.write_strobe), .read_strobe(bfr_if_i.read_strobe),
    .write_side_clock_enable(bfr_if_i.write_side_clock_enable),
    .read_side_clock_enable(bfr_if_i.read_side_clock_enable), .read_data(bfr_if_i.read_data),
    .full_flag(bfr_if_i.full_flag), .almost_full_flag(bfr_if_i.almost_full_flag),
    .almost_empty_flag(bfr_if_i.almost_empty_flag), .empty_flag(bfr_if_i.empty_flag),
    .port_a_reset(bfr_if_i.port_a_reset), .port_b_reset(bfr_if_i.port_b_reset),
    .device_wide_reset_n(bfr_if_i.device_wide_reset_n), .full_thr(bfr_if_i.full_thr),
    .almost_full_thr(bfr_if_i.almost_full_thr), .almost_empty_thr(bfr_if_i.almost_empty_thr));

  always #2.5 pclk = ~pclk;
  // ************************************************
  // tasks
  // ************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [31:0] stv(input logic f, af, ae, e);
    stv                       = 32'h0;
    stv[bfr_pkg::FLG_FULL]   = f;
    stv[bfr_pkg::FLG_AFULL]  = af;
    stv[bfr_pkg::FLG_AEMPTY] = ae;
    stv[bfr_pkg::FLG_EMPTY]  = e;
  endfunction : stv
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // note queued first so the watcher finds it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    @(posedge pclk);
    exp_q.push_back(e);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {1'b0, err, 32'h0});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic err);
    apb(1'b0, a, 32'h0, {1'b1, err, v});
  endtask : rd
  task automatic pa(input logic we, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge pclk);
    port_a_enable <= 1'b1;
    port_a_write  <= we;
    port_a_addr   <= a;
    port_a_wdata  <= d;
    @(posedge pclk);
    port_a_enable <= 1'b0;
    #1;
  endtask : pa
  // ************************************************
  // watcher, timeout and main sequence
  // ************************************************
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
    if (presetn && pready === 1'b1) begin
      note = (exp_q.size() != 0) ? exp_q.pop_front() : 34'h3_ffff_ffff;
      check({31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) check(prdata, note[31:0]);
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(bfr_pkg::OFS_FULL_THR, bfr_pkg::RST_FULL_THR, 1'b0);
    rd(bfr_pkg::OFS_AE_THR, bfr_pkg::RST_AE_THR, 1'b0);
    rd(STAT, stv(1'b0, 1'b0, bfr_pkg::RST_AEMPTY, bfr_pkg::RST_EMPTY), 1'b0);
    rd(RDAT, 32'h0, 1'b1);
    rd(8'h40, 32'h0, 1'b1);
    $display("test reset done");
    wr(ISTA, 32'hf, 1'b0);
    wr(bfr_pkg::OFS_FULL_THR, 32'h4, 1'b0);
    wr(bfr_pkg::OFS_AF_THR, 32'h3, 1'b0);
    wr(bfr_pkg::OFS_AE_THR, 32'h1, 1'b0);
    wr(bfr_pkg::OFS_INT_MASK, stv(1'b0, 1'b0, 1'b0, 1'b1), 1'b0);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      w[i] = r[DW-1:0];
      wr(WDAT, r, 1'b0);
      rd(STAT, stv(i == 3, i >= 2, i == 0, 1'b0), 1'b0);
    end
    wr(WDAT, 32'(w[0]), 1'b1);
    rd(RDAT, 32'(w[0]), 1'b0);
    rd(RDAT, 32'(w[1]), 1'b0);
    wr(CTRL, 32'h1 << bfr_pkg::CTRL_RPTR_RST, 1'b0);
    for (int i = 0; i < 4; i++) rd(RDAT, 32'(w[i]), 1'b0);
    rd(RDAT, 32'h0, 1'b1);
    rd(ISTA, stv(1'b1, 1'b1, 1'b1, 1'b1), 1'b0);
    check({31'h0, irq}, 32'h1);
    wr(ISTA, stv(1'b0, 1'b0, 1'b0, 1'b1), 1'b0);
    rd(ISTA, stv(1'b1, 1'b1, 1'b1, 1'b0), 1'b0);
    check({31'h0, irq}, 32'h0);
    $display("test fill and retransmit done");
    for (int m = 0; m < 3; m++) begin
      @(posedge pclk);
      write_mode <= bfr_pkg::bfr_write_mode_type'(m);
      for (int k = 0; k < 3; k++) begin
        r = xs();
        w[k] = r[DW-1:0] | 9'h001;
      end
      pa(1'b1, 9'h1f0, w[0]);
      pa(1'b1, 9'h1f1, w[1]);
      pa(1'b0, 9'h1f1, '0);
      check(32'(port_a_data), 32'(w[1]));
      pa(1'b1, 9'h1f0, w[2]);
      check(32'(port_a_data), 32'(m == 1 ? w[2] : (m == 2 ? w[0] : w[1])));
      pa(1'b0, 9'h1f0, '0);
      check(32'(port_a_data), 32'(w[2]));
    end
    $display("test port a modes done");
    wr(WDAT, 32'h5a, 1'b0);
    wr(CTRL, 32'h1 << bfr_pkg::CTRL_FIFO_RST, 1'b0);
    rd(STAT, stv(1'b0, 1'b0, 1'b1, 1'b1), 1'b0);
    check(32'(port_a_data), 32'h0);
    rd(RDAT, 32'h0, 1'b1);
    pa(1'b0, 9'h1f0, '0);
    wr(CTRL, 32'h1 << bfr_pkg::CTRL_DEV_RST, 1'b0);
    rd(STAT, stv(1'b0, 1'b0, 1'b1, 1'b1), 1'b0);
    check(32'(port_a_data), 32'h0);
    $display("test resets done");
    finish_test();
  end
endmodule : bfr_tb
`default_nettype wire

// *** verilog/bfr_device.sv ***
// device end: block memory with a random access port a and a fifo
//
// Functional notes
// - normal mode: output changes only on reads
// - write-through mode: output copies written data
// - read-first mode shows old word; 9/18/36
// - separate write and read sides, user driven
// - full and almost-full registered on write side
// - empty and almost-empty registered on read side
// - full, almost thresholds programmable; empty fixed zero
// - fifo reset clears both pointers and flags
// - read-pointer reset rewinds reads for retransmission
// - port resets clear their own output latch
// - device-wide reset clears both output latches
// - user idles enables around asynchronous resets
// - else reset only with steady clocks
// - preloaded memory: device reset released early
// - fifo mode: strobes act as enables
// - fifo and read-pointer resets act asynchronously
// - no sequencing with synchronous reset only
`timescale 1ns/10ps
`default_nettype none
module bfr_device #(
  parameter int DATA_W = bfr_pkg::DATA_W,
  parameter int ADDR_W = bfr_pkg::ADDR_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  bfr_if.device                            lnk,
  input  wire logic                        port_a_enable,
  input  wire logic                        port_a_write,
  input  wire logic [ADDR_W-1:0]           port_a_addr,
  input  wire logic [DATA_W-1:0]           port_a_wdata,
  input  wire bfr_pkg::bfr_write_mode_type write_mode,
  output logic      [DATA_W-1:0]           port_a_data
);

  // ****************************************************************
  // storage and state
  // ****************************************************************
  localparam int DEPTH = 1 << ADDR_W;
  // the old-word option only exists at these widths
  localparam bit READ_FIRST_OK = (DATA_W == 9) || (DATA_W == 18)
                                 || (DATA_W == 36);

  logic [DATA_W-1:0] mem [DEPTH];

  // write-side state: pointer, its flags and the port a latch
  typedef struct packed {
    logic [ADDR_W:0]   wptr;
    logic              full;
    logic              afull;
    logic [DATA_W-1:0] a_data;
  } bfr_wside_type;

  // read-side state: pointer, its flags and the port b latch
  typedef struct packed {
    logic [ADDR_W:0]   rptr;
    logic              empty;
    logic              aempty;
    logic [DATA_W-1:0] b_data;
  } bfr_rside_type;

  bfr_wside_type   w;
  bfr_wside_type   next_w;
  bfr_rside_type   r;
  bfr_rside_type   next_r;

  logic [ADDR_W:0] count;
  logic [ADDR_W:0] next_count;
  logic            at_full;
  logic            push;
  logic            pop;
  logic            a_store;
  logic            rst_w_n;
  logic            rst_r_n;

  // ****************************************************************
  // reset tree
  // ****************************************************************
  // all three resets are plain asynchronous clears; the caller keeps
  // the enables idle around them so no edge races the release
  assign rst_w_n = presetn & lnk.device_wide_reset_n
                   & ~lnk.port_a_reset;
  assign rst_r_n = rst_w_n & ~lnk.port_b_reset;

  // ****************************************************************
  // fifo pointers, flags and port a
  // ****************************************************************
  always_comb begin
    next_w = w;
    next_r = r;
    // pointers carry one extra bit so a full ring differs from an empty one
    count   = w.wptr - r.rptr;
    at_full = count >= {1'b0, lnk.full_thr};
    // write and read strobes only count when their enables are high
    push    = lnk.write_side_clock_enable & lnk.write_strobe
              & ~at_full;
    pop     = lnk.read_side_clock_enable & lnk.read_strobe
              & (count != '0);
    if (push) begin
      next_w.wptr = w.wptr + (ADDR_W + 1)'(1);
    end
    if (pop) begin
      next_r.rptr   = r.rptr + (ADDR_W + 1)'(1);
      next_r.b_data = mem[r.rptr[ADDR_W-1:0]];
    end
    next_count    = next_w.wptr - next_r.rptr;
    // every flag is a compare on the count as it stands after this edge
    next_w.full   = next_count >= {1'b0, lnk.full_thr};
    next_w.afull  = next_count >= {1'b0, lnk.almost_full_thr};
    next_r.empty  = next_count == '0;
    next_r.aempty = next_count <= {1'b0, lnk.almost_empty_thr};

    // port a: random access beside the fifo
    a_store = 1'b0;
    if (port_a_enable) begin
      if (!port_a_write) begin
        next_w.a_data = mem[port_a_addr];
      end else begin
        a_store = 1'b1;
        unique case (write_mode)
          bfr_pkg::WM_NORMAL: begin
            next_w.a_data = w.a_data;
          end
          bfr_pkg::WM_THROUGH: begin
            next_w.a_data = port_a_wdata;
          end
          bfr_pkg::WM_READ_FIRST: begin
            if (READ_FIRST_OK) begin
              next_w.a_data = mem[port_a_addr];
            end
          end
          default: begin
            next_w.a_data = w.a_data;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // full and almost-full live in the write-side group
  always_ff @(posedge pclk or negedge rst_w_n) begin
    if (!rst_w_n) begin
      w <= '0;
    end else begin
      w <= next_w;
    end
  end

  // empty and almost-empty live in the read-side group
  always_ff @(posedge pclk or negedge rst_r_n) begin
    if (!rst_r_n) begin
      r.rptr   <= '0;
      r.empty  <= bfr_pkg::RST_EMPTY;
      r.aempty <= bfr_pkg::RST_AEMPTY;
      r.b_data <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // memory array
  // ****************************************************************
  // the array itself is never cleared, so a read-pointer rewind finds
  // the old words again; a fifo push wins over a port a write
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[w.wptr[ADDR_W-1:0]] <= lnk.write_data;
    end else if (a_store) begin
      mem[port_a_addr] <= port_a_wdata;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign port_a_data           = w.a_data;
  assign lnk.read_data         = r.b_data;
  assign lnk.full_flag         = w.full;
  assign lnk.almost_full_flag  = w.afull;
  assign lnk.empty_flag        = r.empty;
  assign lnk.almost_empty_flag = r.aempty;

endmodule : bfr_device
`default_nettype wire

// *** verilog/bfr_host.sv ***
// host end: apb register front that drives the fifo and sequences its resets
`timescale 1ns/10ps
`default_nettype none
module bfr_host #(
  parameter int DATA_W = bfr_pkg::DATA_W,
  parameter int ADDR_W = bfr_pkg::ADDR_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  bfr_if.host              lnk
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    bfr_pkg::bfr_host_state_type state;
    logic [2:0]                  seq_sel;
    logic                        ce_w;
    logic                        strobe_w;
    logic [DATA_W-1:0]           wdata;
    logic                        ce_r;
    logic                        strobe_r;
    logic                        rst_a;
    logic                        rst_b;
    logic                        dev_rst;
    logic [ADDR_W-1:0]           full_thr;
    logic [ADDR_W-1:0]           af_thr;
    logic [ADDR_W-1:0]           ae_thr;
    logic [3:0]                  flags_q;
    logic [3:0]                  int_status;
    logic [3:0]                  int_mask;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic                        irq;
  } bfr_host_regs_type;

  bfr_host_regs_type s;
  bfr_host_regs_type next_s;
  logic [3:0]        flags;
  logic [3:0]        w1c;
  logic              access;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s          = s;
    next_s.ce_w     = 1'b0;
    next_s.strobe_w = 1'b0;
    next_s.ce_r     = 1'b0;
    next_s.strobe_r = 1'b0;
    next_s.pready   = 1'b0;
    next_s.pslverr  = 1'b0;
    w1c             = 4'h0;
    flags           = {lnk.empty_flag, lnk.almost_empty_flag,
                       lnk.almost_full_flag, lnk.full_flag};
    next_s.flags_q  = flags;
    // only idle serves an access; other states add wait cycles
    access          = psel & penable & ~s.pready;
    unique case (s.state)
      bfr_pkg::ST_IDLE: begin
        if (access) begin
          next_s.pready = 1'b1;
          next_s.prdata = 32'h0000_0000;
          if (pwrite) begin
            case (paddr)
              bfr_pkg::OFS_CTRL: begin
                next_s.seq_sel = pwdata[2:0];
                if (|pwdata[2:0]) begin
                  next_s.state = bfr_pkg::ST_QUIET;
                end
              end
              bfr_pkg::OFS_WDATA: begin
                if (lnk.full_flag) begin
                  next_s.pslverr = 1'b1;
                end else begin
                  next_s.ce_w     = 1'b1;
                  next_s.strobe_w = 1'b1;
                  next_s.wdata    = pwdata[DATA_W-1:0];
                end
              end
              bfr_pkg::OFS_FULL_THR: next_s.full_thr   = pwdata[ADDR_W-1:0];
              bfr_pkg::OFS_AF_THR:   next_s.af_thr     = pwdata[ADDR_W-1:0];
              bfr_pkg::OFS_AE_THR:   next_s.ae_thr     = pwdata[ADDR_W-1:0];
              bfr_pkg::OFS_INT_STAT: w1c               = pwdata[3:0];
              bfr_pkg::OFS_INT_MASK: next_s.int_mask   = pwdata[3:0];
              default:               next_s.pslverr    = 1'b1;
            endcase
          end else begin
            case (paddr)
              bfr_pkg::OFS_CTRL:     next_s.prdata[2:0]        = s.seq_sel;
              bfr_pkg::OFS_STATUS:   next_s.prdata[3:0]        = flags;
              bfr_pkg::OFS_FULL_THR: next_s.prdata[ADDR_W-1:0] = s.full_thr;
              bfr_pkg::OFS_AF_THR:   next_s.prdata[ADDR_W-1:0] = s.af_thr;
              bfr_pkg::OFS_AE_THR:   next_s.prdata[ADDR_W-1:0] = s.ae_thr;
              bfr_pkg::OFS_INT_STAT: next_s.prdata[3:0]        = s.int_status;
              bfr_pkg::OFS_INT_MASK: next_s.prdata[3:0]        = s.int_mask;
              bfr_pkg::OFS_RDATA: begin
                if (lnk.empty_flag) begin
                  next_s.pslverr = 1'b1;
                end else begin
                  next_s.pready   = 1'b0;
                  next_s.ce_r     = 1'b1;
                  next_s.strobe_r = 1'b1;
                  next_s.state    = bfr_pkg::ST_POP1;
                end
              end
              default: next_s.pslverr = 1'b1;
            endcase
          end
        end
      end
      // popped word reaches the latch one edge after the strobe
      bfr_pkg::ST_POP1: next_s.state = bfr_pkg::ST_POP2;
      bfr_pkg::ST_POP2: begin
        next_s.prdata              = 32'h0000_0000;
        next_s.prdata[DATA_W-1:0]  = lnk.read_data;
        next_s.pready              = 1'b1;
        next_s.state               = bfr_pkg::ST_IDLE;
      end
      // enables idle one full cycle before any reset rises
      bfr_pkg::ST_QUIET: begin
        next_s.rst_a   = s.seq_sel[bfr_pkg::CTRL_FIFO_RST];
        next_s.rst_b   = s.seq_sel[bfr_pkg::CTRL_RPTR_RST];
        next_s.dev_rst = s.seq_sel[bfr_pkg::CTRL_DEV_RST];
        next_s.state   = bfr_pkg::ST_PULSE;
      end
      bfr_pkg::ST_PULSE: begin
        next_s.rst_a   = 1'b0;
        next_s.rst_b   = 1'b0;
        next_s.dev_rst = 1'b0;
        next_s.state   = bfr_pkg::ST_HOLD;
      end
      // one quiet cycle after release
      bfr_pkg::ST_HOLD: next_s.state = bfr_pkg::ST_IDLE;
      default: next_s.state = bfr_pkg::ST_IDLE;
    endcase
    // a flag edge in the clearing cycle wins over the clear
    next_s.int_status = (s.int_status & ~w1c) | (flags & ~s.flags_q);
    next_s.irq        = |(next_s.int_status & next_s.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.full_thr <= bfr_pkg::RST_FULL_THR[ADDR_W-1:0];
      s.af_thr   <= bfr_pkg::RST_AF_THR[ADDR_W-1:0];
      s.ae_thr   <= bfr_pkg::RST_AE_THR[ADDR_W-1:0];
      s.flags_q  <= {bfr_pkg::RST_EMPTY, bfr_pkg::RST_AEMPTY, 2'b00};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign lnk.write_data = s.wdata;
  assign lnk.write_side_clock_enable = s.ce_w;
  assign lnk.write_strobe = s.strobe_w;
  assign lnk.read_side_clock_enable = s.ce_r;
  assign lnk.read_strobe = s.strobe_r;
  assign lnk.port_a_reset = s.rst_a;
  assign lnk.port_b_reset = s.rst_b;
  assign lnk.device_wide_reset_n = ~s.dev_rst;
  assign lnk.full_thr = s.full_thr;
  assign lnk.almost_full_thr = s.af_thr;
  assign lnk.almost_empty_thr = s.ae_thr;

endmodule : bfr_host
`default_nettype wire

// *** verilog/bfr_if.sv ***
// interface: fifo write side, read side, flags, thresholds and resets
`timescale 1ns/10ps
`default_nettype none
interface bfr_if #(
  parameter int DATA_W = bfr_pkg::DATA_W,
  parameter int ADDR_W = bfr_pkg::ADDR_W
);
  logic [DATA_W-1:0] write_data;
  logic              write_side_clock_enable;
  logic              write_strobe;
  logic [DATA_W-1:0] read_data;
  logic              read_side_clock_enable;
  logic              read_strobe;
  logic              full_flag;
  logic              almost_full_flag;
  logic              almost_empty_flag;
  logic              empty_flag;
  logic              port_a_reset;
  logic              port_b_reset;
  logic              device_wide_reset_n;
  logic [ADDR_W-1:0] full_thr;
  logic [ADDR_W-1:0] almost_full_thr;
  logic [ADDR_W-1:0] almost_empty_thr;

  modport device (
    input  write_data, write_side_clock_enable, write_strobe,
    input  read_side_clock_enable, read_strobe,
    input  port_a_reset, port_b_reset, device_wide_reset_n,
    input  full_thr, almost_full_thr, almost_empty_thr,
    output read_data, full_flag, almost_full_flag, almost_empty_flag, empty_flag
  );

  modport host (
    output write_data, write_side_clock_enable, write_strobe,
    output read_side_clock_enable, read_strobe,
    output port_a_reset, port_b_reset, device_wide_reset_n,
    output full_thr, almost_full_thr, almost_empty_thr,
    input  read_data, full_flag, almost_full_flag, almost_empty_flag, empty_flag
  );
endinterface : bfr_if
`default_nettype wire

// *** verilog/bfr_pkg.sv ***
// package: constants and types shared by the block memory fifo ends
package bfr_pkg;
  localparam int          DATA_W        = 9;
  localparam int          ADDR_W        = 9;
  // register offsets of the host end
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_WDATA     = 8'h08;
  localparam logic [7:0]  OFS_RDATA     = 8'h0c;
  localparam logic [7:0]  OFS_FULL_THR  = 8'h10;
  localparam logic [7:0]  OFS_AF_THR    = 8'h14;
  localparam logic [7:0]  OFS_AE_THR    = 8'h18;
  localparam logic [7:0]  OFS_INT_STAT  = 8'h1c;
  localparam logic [7:0]  OFS_INT_MASK  = 8'h20;
  // control bits and flag positions
  localparam int          CTRL_FIFO_RST = 0;
  localparam int          CTRL_RPTR_RST = 1;
  localparam int          CTRL_DEV_RST  = 2;
  localparam int          FLG_FULL      = 0;
  localparam int          FLG_AFULL     = 1;
  localparam int          FLG_AEMPTY    = 2;
  localparam int          FLG_EMPTY     = 3;
  // values after reset
  localparam logic [31:0] RST_FULL_THR  = 32'h0000_01ff;
  localparam logic [31:0] RST_AF_THR    = 32'h0000_01f0;
  localparam logic [31:0] RST_AE_THR    = 32'h0000_0010;
  localparam logic        RST_EMPTY     = 1'b1;
  localparam logic        RST_AEMPTY    = 1'b1;

  typedef enum logic [1:0] {
    WM_NORMAL     = 2'b00,
    WM_THROUGH    = 2'b01,
    WM_READ_FIRST = 2'b10
  } bfr_write_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_POP1  = 3'b001,
    ST_POP2  = 3'b010,
    ST_QUIET = 3'b011,
    ST_PULSE = 3'b100,
    ST_HOLD  = 3'b101
  } bfr_host_state_type;
endpackage : bfr_pkg
